/* design/cib_exec.v */
// Execution unit for clear, increment/decrement, OR and branch operations
`timescale 1ns/1ps
`include "cib_regs.vh"
module cib_exec (
  input  wire                     CORE_CLK_I,        // Core clock, 40 MHz
  input  wire                     SRST_I,            // Synchronous reset, active high
  input  wire                     OP_VALID_I,        // Decoded instruction presented
  input  wire [`CIB_OP_W-1:0]     OP_CODE_I,         // Operation code
  input  wire [`CIB_FADDR_W-1:0]  FILE_ADDR_I,       // File register address 0..127
  input  wire                     DEST_SEL_I,        // 0 accumulator, 1 file register
  input  wire [`CIB_DATA_W-1:0]   LITERAL_I,         // 8-bit literal
  input  wire [`CIB_IMM_W-1:0]    BRANCH_IMM_I,      // Branch target 0..2047
  input  wire [`CIB_DATA_W-1:0]   FILE_RDATA_I,      // Addressed file register contents
  input  wire [`CIB_LATCH_W-1:0]  PC_HIGH_LATCH_I,   // Program counter high latch
  output reg                      OP_READY_O,        // Instruction will be taken
  output reg  [`CIB_DATA_W-1:0]   ACC_O,             // Working accumulator
  output reg                      ZERO_FLAG_O,       // Zero flag
  output reg                      FILE_WE_O,         // File write pulse
  output reg  [`CIB_FADDR_W-1:0]  FILE_WADDR_O,      // File write address
  output reg  [`CIB_DATA_W-1:0]   FILE_WDATA_O,      // File write data
  output reg                      PC_LOAD_O,         // Program counter load pulse
  output reg  [`CIB_PC_W-1:0]     PROGRAM_COUNTER_O, // Branch target counter
  output reg                      FLUSH_O            // Next fetched word becomes no-operation
);
  // Sequencer states: the second state is the inserted no-operation slot
  localparam ST_RUN   = 1'b0;   // Taking instructions
  localparam ST_SLOT2 = 1'b1;   // Extra cycle of a branch or of a met skip

  // Sequencer
  reg                     state_r;        // Sequencer state
  reg                     state_nxt;      // Next sequencer state

  // Arithmetic unit
  wire [`CIB_DATA_W-1:0]  result;         // Unit result
  wire                    result_zero;    // Unit result is zero

  // Operation decode
  wire                    take;           // Instruction accepted this cycle
  wire                    op_clear;       // Clear accumulator
  wire                    op_dec_skip;    // Decrement, skip if zero
  wire                    op_inc_skip;    // Increment, skip if zero
  wire                    op_inc;         // Plain increment
  wire                    op_branch;      // Unconditional branch
  wire                    op_or_lit;      // OR with literal
  wire                    op_or_file;     // OR with file register
  wire                    is_skip;        // Either skip operation
  wire                    skip_met;       // Skip taken: next word is discarded
  wire                    has_data;       // Operation produces a data result
  wire                    to_file;        // Result heads for file register
  wire                    sets_zero;      // Operation updates the zero flag
  wire [`CIB_PC_W-1:0]    branch_target;  // Assembled branch destination

  // Next values of the registered outputs
  reg                     ready_nxt;      // Next ready level
  reg  [`CIB_DATA_W-1:0]  acc_nxt;        // Next accumulator
  reg                     zero_nxt;       // Next zero flag
  reg                     we_nxt;         // Next file write pulse
  reg  [`CIB_FADDR_W-1:0] waddr_nxt;      // Next file write address
  reg  [`CIB_DATA_W-1:0]  wdata_nxt;      // Next file write data
  reg                     pc_load_nxt;    // Next counter load pulse
  reg  [`CIB_PC_W-1:0]    pc_nxt;         // Next branch target
  reg                     flush_nxt;      // Next discard marker

  // Shared arithmetic: one adder and OR path serve every data operation
  cib_alu u_alu (
    .op_i     (OP_CODE_I),
    .acc_i    (ACC_O),
    .file_i   (FILE_RDATA_I),
    .lit_i    (LITERAL_I),
    .result_o (result),
    .zero_o   (result_zero)
  );

  // Instructions are taken only while ready is shown and the run state holds.
  // Ready stays low through reset and the first cycle after it, so a word
  // left on the bus while reset is held is never executed as reset lets go.
  assign take          = OP_VALID_I && OP_READY_O && (state_r == ST_RUN);

  // One-hot view of the operation code
  assign op_clear      = (OP_CODE_I == `CIB_OP_CLEAR_ACC);
  assign op_dec_skip   = (OP_CODE_I == `CIB_OP_DEC_SKIP);
  assign op_inc_skip   = (OP_CODE_I == `CIB_OP_INC_SKIP);
  assign op_inc        = (OP_CODE_I == `CIB_OP_INC_FILE);
  assign op_branch     = (OP_CODE_I == `CIB_OP_BRANCH);
  assign op_or_lit     = (OP_CODE_I == `CIB_OP_OR_LITERAL);
  assign op_or_file    = (OP_CODE_I == `CIB_OP_OR_FILE);
  assign is_skip       = op_dec_skip || op_inc_skip;

  // A skip whose result wrapped to zero discards the next word
  assign skip_met      = take && is_skip && result_zero;

  // No-operation and branch leave the data path alone
  assign has_data      = op_clear || op_dec_skip || op_inc_skip || op_inc
                         || op_or_lit || op_or_file;

  // Only file-form operations honour the select bit; the others use the accumulator
  assign to_file       = DEST_SEL_I && (op_dec_skip || op_inc_skip || op_inc
                         || op_or_file);

  // The skips leave every status flag alone; clear, plain increment and both ORs update the zero flag
  assign sets_zero     = op_clear || op_inc || op_or_lit || op_or_file;

  // Upper counter bits come from the latch, lower bits from the immediate.
  // The latch bits below the field are ignored, so software may leave junk there.
  assign branch_target = {PC_HIGH_LATCH_I[`CIB_LATCH_HI:`CIB_LATCH_LO],
                          BRANCH_IMM_I};

  // Next state: a taken branch or a met skip costs one extra cycle
  always @* begin
    case (state_r)
      ST_RUN: begin
        if (skip_met || (take && op_branch)) begin
          state_nxt = ST_SLOT2;
        end else begin
          state_nxt = ST_RUN;
        end
      end
      // The inserted slot always returns to the run state
      ST_SLOT2: begin
        state_nxt = ST_RUN;
      end
      // Unused codes recover to the run state
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // Ready falls during the inserted slot so fetch holds the next word
  always @* begin
    ready_nxt = (state_nxt == ST_RUN);
  end

  // Accumulator and zero flag hold unless a data operation targets them
  always @* begin
    acc_nxt  = ACC_O;
    zero_nxt = ZERO_FLAG_O;
    if (take && has_data) begin
      // Results not bound for the file land in the accumulator
      if (!to_file) begin
        acc_nxt = result;
      end
      // Skips keep the flag so a loop test does not disturb it
      if (sets_zero) begin
        zero_nxt = result_zero;
      end
    end
  end

  // File write port: address and data hold between writes, the enable pulses
  always @* begin
    we_nxt    = 1'b0;
    waddr_nxt = FILE_WADDR_O;
    wdata_nxt = FILE_WDATA_O;
    if (take && has_data && to_file) begin
      we_nxt    = 1'b1;
      waddr_nxt = FILE_ADDR_I;
      wdata_nxt = result;
    end
  end

  // Counter load: the target holds after the pulse so fetch may read it late
  always @* begin
    pc_load_nxt = 1'b0;
    pc_nxt      = PROGRAM_COUNTER_O;
    if (take && op_branch) begin
      pc_load_nxt = 1'b1;
      pc_nxt      = branch_target;
    end
  end

  // Discard marker: one pulse on the cycle whose fetched word is dropped
  always @* begin
    flush_nxt = skip_met;
  end

  // Sequencer register
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Handshake and pulse outputs
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      // Nothing is taken while reset is held, nor on the first edge after it
      OP_READY_O <= 1'b0;
      FILE_WE_O  <= 1'b0;
      PC_LOAD_O  <= 1'b0;
      FLUSH_O    <= 1'b0;
    end else begin
      OP_READY_O <= ready_nxt;
      FILE_WE_O  <= we_nxt;
      PC_LOAD_O  <= pc_load_nxt;
      FLUSH_O    <= flush_nxt;
    end
  end

  // Accumulator and zero flag registers
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      ACC_O       <= `CIB_ZERO_BYTE;
      ZERO_FLAG_O <= 1'b0;
    end else begin
      ACC_O       <= acc_nxt;
      ZERO_FLAG_O <= zero_nxt;
    end
  end

  // File write address and data registers
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      FILE_WADDR_O <= `CIB_ADDR_RST;
      FILE_WDATA_O <= `CIB_ZERO_BYTE;
    end else begin
      FILE_WADDR_O <= waddr_nxt;
      FILE_WDATA_O <= wdata_nxt;
    end
  end

  // Branch target register
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      PROGRAM_COUNTER_O <= `CIB_PC_RST;
    end else begin
      PROGRAM_COUNTER_O <= pc_nxt;
    end
  end

endmodule // cib_exec

/* include/cib_regs.vh */
// Constants for the increment/decrement, OR and branch execution block
// Contract
// - Clear accumulator loads zero, sets zero flag
// - Decrement-skip subtracts one from file register 0..127
// - Select zero writes accumulator, one writes file
// - Decrement-skip zero result replaces next with no-op
// - Increments add one, routed by select bit
// - Increment-skip zero result makes two-cycle no-op
// - Branch loads 11-bit immediate into counter low
// - Branch fills counter 14:11 from latch 6:3
// - Branch immediate accepts 0 to 2047
// - Branch takes two instruction cycles
// - OR literal: accumulator OR 8-bit literal to accumulator
// - OR file: accumulator OR file to destination
// - Skip unmet continues; met inserts no-op cycle
`ifndef CIB_REGS_VH
`define CIB_REGS_VH
// Operation codes presented by the fetch logic
`define CIB_OP_W            3
`define CIB_OP_NONE         3'h0
`define CIB_OP_CLEAR_ACC    3'h1
`define CIB_OP_DEC_SKIP     3'h2
`define CIB_OP_INC_SKIP     3'h3
`define CIB_OP_INC_FILE     3'h4
`define CIB_OP_BRANCH       3'h5
`define CIB_OP_OR_LITERAL   3'h6
`define CIB_OP_OR_FILE      3'h7
// Widths
`define CIB_DATA_W          8
`define CIB_FADDR_W         7
`define CIB_IMM_W           11
`define CIB_PC_W            15
`define CIB_LATCH_W         7
// Field positions
`define CIB_LATCH_HI        6
`define CIB_LATCH_LO        3
// Reset values and the increment/decrement step
`define CIB_ZERO_BYTE       8'h00
`define CIB_PC_RST          15'h0000
`define CIB_ADDR_RST        7'h00
`define CIB_ONE_BYTE        8'h01
`endif

/* design/cib_alu.v */
// Combinational arithmetic unit for the execution block
`timescale 1ns/1ps
`include "cib_regs.vh"
module cib_alu (
  input  wire [`CIB_OP_W-1:0]   op_i,     // Operation code
  input  wire [`CIB_DATA_W-1:0] acc_i,    // Accumulator value
  input  wire [`CIB_DATA_W-1:0] file_i,   // Addressed file register value
  input  wire [`CIB_DATA_W-1:0] lit_i,    // 8-bit literal
  output reg  [`CIB_DATA_W-1:0] result_o, // Operation result
  output wire                   zero_o    // Result is zero
);
  // Result selection per operation
  always @* begin
    case (op_i)
      `CIB_OP_CLEAR_ACC:  result_o = `CIB_ZERO_BYTE;
      `CIB_OP_DEC_SKIP:   result_o = file_i - `CIB_ONE_BYTE;
      `CIB_OP_INC_SKIP:   result_o = file_i + `CIB_ONE_BYTE;
      `CIB_OP_INC_FILE:   result_o = file_i + `CIB_ONE_BYTE;
      `CIB_OP_OR_LITERAL: result_o = acc_i | lit_i;
      `CIB_OP_OR_FILE:    result_o = acc_i | file_i;
      default:            result_o = `CIB_ZERO_BYTE;                 // No data result
    endcase
  end
  assign zero_o = (result_o == `CIB_ZERO_BYTE);
endmodule // cib_alu

/* dv/cib_exec_sva.sv */
// Port assertions for the execution block
`timescale 1ns/1ps
module cib_exec_sva (
  input wire        CORE_CLK_I,        // Core clock
  input wire        SRST_I,            // Synchronous reset, active high
  input wire        OP_VALID_I,        // Instruction presented
  input wire [2:0]  OP_CODE_I,         // Operation code
  input wire [6:0]  FILE_ADDR_I,       // File address
  input wire        DEST_SEL_I,        // Destination select
  input wire [7:0]  LITERAL_I,         // Literal
  input wire [10:0] BRANCH_IMM_I,      // Branch immediate
  input wire [7:0]  FILE_RDATA_I,      // Addressed file contents
  input wire [6:0]  PC_HIGH_LATCH_I,   // Counter high latch
  input wire        OP_READY_O,        // Ready
  input wire [7:0]  ACC_O,             // Accumulator
  input wire        ZERO_FLAG_O,       // Zero flag
  input wire        FILE_WE_O,         // File write pulse
  input wire [6:0]  FILE_WADDR_O,      // File write address
  input wire [7:0]  FILE_WDATA_O,      // File write data
  input wire        PC_LOAD_O,         // Counter load pulse
  input wire [14:0] PROGRAM_COUNTER_O, // Branch target
  input wire        FLUSH_O            // Discard marker
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  wire go=OP_VALID_I&&OP_READY_O; // Instruction taken at this edge
  wire [2:0] o=OP_CODE_I;
  wire [7:0] f=FILE_RDATA_I, ow=ACC_O|FILE_RDATA_I;
  wire [3:0] hl=PC_HIGH_LATCH_I[6:3]; // Only these latch bits reach the counter
  wire sk=go&&(o==3'h2&&f==8'h01||o==3'h3&&f==8'hff); // Skip whose result wraps to zero
  property p_clr; go&&o==3'h1 |=> ACC_O==8'h00&&ZERO_FLAG_O; endproperty
  a_clr: assert property(p_clr) else $error("clear wrong");
  property p_orl; go&&o==3'h6 |=> ACC_O==($past(ACC_O)|$past(LITERAL_I)); endproperty
  a_orl: assert property(p_orl) else $error("or literal wrong");
  property p_dec; go&&o==3'h2&&DEST_SEL_I |=> FILE_WE_O&&FILE_WDATA_O==$past(f)-8'h01
    &&FILE_WADDR_O==$past(FILE_ADDR_I); endproperty
  a_dec: assert property(p_dec) else $error("decrement wrong");
  property p_inc; go&&(o==3'h3||o==3'h4)&&!DEST_SEL_I |=> ACC_O==$past(f)+8'h01&&!FILE_WE_O;
  endproperty
  a_inc: assert property(p_inc) else $error("increment wrong");
  property p_met; sk |=> FLUSH_O&&!OP_READY_O&&$stable(ZERO_FLAG_O) ##1 OP_READY_O&&!FLUSH_O;
  endproperty
  a_met: assert property(p_met) else $error("skip wrong");
  property p_unm; go&&(o==3'h2||o==3'h3)&&!sk |=> !FLUSH_O&&OP_READY_O; endproperty
  a_unm: assert property(p_unm) else $error("unmet skip wrong");
  property p_br; go&&o==3'h5 |=> PC_LOAD_O&&!OP_READY_O&&PROGRAM_COUNTER_O=={$past(hl),
    $past(BRANCH_IMM_I)} ##1 OP_READY_O&&!PC_LOAD_O; endproperty
  a_br: assert property(p_br) else $error("branch wrong");
  property p_orf; go&&o==3'h7 |=> ($past(DEST_SEL_I)?FILE_WDATA_O:ACC_O)==$past(ow)
    &&ZERO_FLAG_O==($past(ow)==8'h00); endproperty
  a_orf: assert property(p_orf) else $error("or file wrong");
  // Nothing taken means nothing changes, also on the edges just after reset
  property p_idle; !go |=> !FILE_WE_O&&!PC_LOAD_O&&!FLUSH_O&&$stable(ACC_O)
    &&$stable(ZERO_FLAG_O); endproperty
  a_idle: assert property(p_idle) else $error("idle cycle changed state");
  c_met: cover property(sk);
  c_br: cover property(go&&o==3'h5);
  c_orf: cover property(go&&o==3'h7&&DEST_SEL_I);
endmodule // cib_exec_sva

/* dv/cib_file_model.sv */
// File register model on the far side of the execution block
`timescale 1ns/1ps
module cib_file_model(
  input              clk_i,
  input              we_i,
  input        [6:0] waddr_i,
  input        [6:0] raddr_i,
  input        [7:0] wdata_i,
  output logic [7:0] rdata_o);
  logic [7:0] mem [128]; // Entry 0 starts at ff and entry 1 at 01 so skips can hit
  initial foreach (mem[i]) mem[i] = 8'(2*i-1);
  assign rdata_o = mem[raddr_i]; // Same-cycle read, as the core provides
  always @(posedge clk_i) if (we_i) mem[waddr_i] <= wdata_i;
endmodule // cib_file_model

/* dv/test_cpu_incdec_or_branch_exec.sv */
// Self-checking bench for the execution block
`timescale 1ns/1ps
module test_cpu_incdec_or_branch_exec;
  logic clk=0, srst=1, vld=0, dsel=0, ready, zf, we, pcl, fl, pend=0, z=0;
  logic [2:0] op=0;
  logic [6:0] fa=0, wa, hl=0;
  logic [7:0] lit=0, rd, acc, wd, w=0;
  logic [10:0] imm=0;
  logic [14:0] pc;
  logic [41:0] q[$];
  int err_count=0, n_tests=0, seed=21416, n;
  wire [41:0] seen={acc,zf,we,pcl,fl,we?{wa,wd}:15'h0,pcl?pc:15'h0};
  cib_exec dut_u (.CORE_CLK_I(clk), .SRST_I(srst), .OP_VALID_I(vld), .OP_CODE_I(op),
    .FILE_ADDR_I(fa), .DEST_SEL_I(dsel), .LITERAL_I(lit), .BRANCH_IMM_I(imm), .FILE_RDATA_I(rd),
    .PC_HIGH_LATCH_I(hl), .OP_READY_O(ready), .ACC_O(acc), .ZERO_FLAG_O(zf), .FILE_WE_O(we),
    .FILE_WADDR_O(wa), .FILE_WDATA_O(wd), .PC_LOAD_O(pcl), .PROGRAM_COUNTER_O(pc), .FLUSH_O(fl));
  cib_file_model fm_u (.clk_i(clk), .we_i(we), .waddr_i(wa), .raddr_i(fa), .wdata_i(wd),
    .rdata_o(rd));
  always #12.5 clk = ~clk;
  task automatic chk(input [41:0] x, input [41:0] s);
    n_tests++;
    if (s !== x) begin err_count++; $display("unexpected outputs exp %h seen %h", x, s); end
  endtask
  task automatic test_done;
    $display("mismatches %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Drive one instruction once ready, and note its expected outputs
  task automatic issue(input [2:0] o, input [6:0] a, input d, input [7:0] l, input [10:0] i);
    logic [7:0] r; logic wb, fb, pb, fo; int k;
    @(negedge clk);
    for (k = 0; k < 4 && ready !== 1'b1; k++) @(negedge clk);
    if (k == 4) begin err_count++; test_done; end
    op = o; fa = a; dsel = d; lit = l; imm = i; vld = 1; hl = 7'($random(seed));
    r = 8'h00; fo = o inside {3'h2, 3'h3, 3'h4, 3'h7};
    case (o)
      3'h1: begin w = 8'h00; z = 1; end
      3'h2: r = fm_u.mem[a] - 8'h01;
      3'h3, 3'h4: r = fm_u.mem[a] + 8'h01;
      3'h6: begin w = w | l; z = (w == 8'h00); end
      3'h7: r = w | fm_u.mem[a];
      default: ;
    endcase
    wb = fo && d;
    if (fo && !d) w = r;
    if (o == 3'h4 || o == 3'h7) z = (r == 8'h00);
    fb = (o == 3'h2 || o == 3'h3) && r == 8'h00;
    pb = o == 3'h5;
    q.push_back({w, z, wb, pb, fb, wb ? {a, r} : 15'h0, pb ? {hl[6:3], i} : 15'h0});
  endtask
  // Each taken instruction shows its outputs one cycle later
  always @(posedge clk) pend <= !srst && vld && ready;
  always @(negedge clk) if (pend) chk(q.size() > 0 ? q.pop_front() : '1, seen);
  initial begin
    logic [31:0] v;
    repeat (16) @(negedge clk);
    srst = 0;
    chk(42'h0, seen);
    issue(3'h3, 7'h00, 1'b0, 8'h00, 11'h000);
    issue(3'h2, 7'h01, 1'b1, 8'h00, 11'h000);
    issue(3'h5, 7'h7f, 1'b0, 8'h00, 11'h7ff);
    issue(3'h1, 7'h00, 1'b0, 8'h00, 11'h000);
    issue(3'h6, 7'h00, 1'b0, 8'hff, 11'h000);
    for (n = 0; n < 300; n++) begin
      v = $random(seed);
      if (n == 150) begin
        @(negedge clk) srst = 1;
        repeat (2) @(negedge clk);
        srst = 0; w = 0; z = 0; q.delete();
        // Outputs must be back at their reset values; the stale word on the bus must not run
        chk(42'h0, seen);
      end
      issue(v[2:0], v[3] ? v[10:4] : {4'h0, v[6:4]}, v[11], v[19:12], v[30:20]);
    end
    @(negedge clk) vld = 0;
    repeat (4) @(negedge clk);
    test_done;
  end
endmodule // test_cpu_incdec_or_branch_exec
bind cib_exec cib_exec_sva chk_u (.*);
